//--- shared/srsf_pkg.sv
package srsf_pkg;

  // Register addresses on the plain register port
  localparam logic [7:0] SRSF_ADDR_STATUS = 8'h2B;
  localparam logic [7:0] SRSF_ADDR_SYNC = 8'h27;
  localparam logic [7:0] SRSF_ADDR_CTRL = 8'h29;
  localparam logic [7:0] SRSF_ADDR_DATA = 8'h2F;

  // Receiver status bit positions
  localparam int unsigned SRSF_STS_BF = 7;
  localparam int unsigned SRSF_STS_OE = 6;
  localparam int unsigned SRSF_STS_PE = 5;
  localparam int unsigned SRSF_STS_FE = 4;
  localparam int unsigned SRSF_STS_FSB = 3;
  localparam int unsigned SRSF_STS_MCIP = 2;
  localparam int unsigned SRSF_STS_SS = 1;
  localparam int unsigned SRSF_STS_RE = 0;

  // Control bit positions
  localparam int unsigned SRSF_CTL_SYNC = 0;
  localparam int unsigned SRSF_CTL_WL = 1;
  localparam int unsigned SRSF_CTL_PAR = 3;
  localparam int unsigned SRSF_CTL_EVEN = 4;
  localparam int unsigned SRSF_CTL_AUTO = 5;

  // Reset values
  localparam logic [7:0] SRSF_STATUS_RST = 8'h00;
  localparam logic [7:0] SRSF_CTRL_RST = 8'h00;
  localparam logic [7:0] SRSF_SYNC_RST = 8'h00;
  localparam logic [7:0] SRSF_DATA_RST = 8'h00;

  // Longest word: eight data bits
  localparam logic [3:0] SRSF_MAX_BITS = 4'h8;

  typedef enum logic [3:0] {
    SRSF_IDLE = 4'b0001,
    SRSF_DATA = 4'b0010,
    SRSF_STOP = 4'b0100,
    SRSF_HUNT = 4'b1000
  } srsf_rx_t;

endpackage

//--- src/srsf_pin_sync.sv
`timescale 1ns/100ps
module srsf_pin_sync
  import srsf_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic rx_clk_pin,
  input wire logic rx_data_pin,
  output logic bit_tick,
  output logic bit_val
);

  typedef struct packed {
    logic clk_s1;
    logic clk_s2;
    logic clk_s3;
    logic dat_s1;
    logic dat_s2;
    logic tick;
    logic val;
  } srsf_sync_t;

  srsf_sync_t cur_ff;
  srsf_sync_t nxt_ff;

  always_comb
  begin
    nxt_ff = cur_ff;
    nxt_ff.clk_s1 = rx_clk_pin;
    nxt_ff.clk_s2 = cur_ff.clk_s1;
    nxt_ff.clk_s3 = cur_ff.clk_s2;
    nxt_ff.dat_s1 = rx_data_pin;
    nxt_ff.dat_s2 = cur_ff.dat_s1;
    // Rising receiver clock edge samples the line
    nxt_ff.tick = cur_ff.clk_s2 & ~cur_ff.clk_s3;
    nxt_ff.val = cur_ff.dat_s2;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      cur_ff <= '{default: 1'b0, dat_s1: 1'b1, dat_s2: 1'b1, val: 1'b1};
    end
    else
    begin
      cur_ff <= nxt_ff;
    end
  end

  assign bit_tick = cur_ff.tick;
  assign bit_val = cur_ff.val;

endmodule

//--- src/srsf_receiver.sv
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps
module srsf_receiver
  import srsf_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic rx_clk_pin,
  input wire logic rx_data_pin,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic tx_enabled,
  input wire logic err_chan_en,
  output logic irq_buffer_full,
  output logic irq_rx_error,
  output logic rx_enabled
);

  typedef struct packed {
    srsf_rx_t st;
    logic [3:0] cnt;
    logic [8:0] shf;
    logic [7:0] ctrl;
    logic [7:0] sync_chr;
    logic [7:0] data_buf;
    logic bf;
    logic oe;
    logic pe;
    logic fe;
    logic fs;
    logic brk;
    logic m;
    logic char_in_progress_flag;
    logic ss;
    logic re;
    logic ovr_pend;
    logic brk_pend;
    logic brk_act;
    logic brk_rd;
    logic tx_en_d;
    logic [7:0] rdata;
    logic irq_full;
    logic irq_err;
  } srsf_state_t;

  srsf_state_t cur_ff;
  srsf_state_t nxt_ff;

  logic tick;
  logic bitv;

  srsf_pin_sync u_pin_sync (
    .clock(clock),
    .rst(rst),
    .rx_clk_pin(rx_clk_pin),
    .rx_data_pin(rx_data_pin),
    .bit_tick(tick),
    .bit_val(bitv)
  );

  // Decoded format settings
  logic sync_fmt;
  logic par_en;
  logic par_even;
  logic [3:0] n_data;
  logic [3:0] n_word;
  logic [7:0] data_mask;

  assign sync_fmt = cur_ff.ctrl[SRSF_CTL_SYNC];
  assign par_en = cur_ff.ctrl[SRSF_CTL_PAR];
  assign par_even = cur_ff.ctrl[SRSF_CTL_EVEN];
  assign n_data = SRSF_MAX_BITS - {2'b00, cur_ff.ctrl[SRSF_CTL_WL +: 2]};
  assign n_word = n_data + {3'b000, par_en};
  assign data_mask = 8'(9'h0FF >> (SRSF_MAX_BITS - n_data));

  // Word as it stands after the next shift
  logic [8:0] shf_next;
  logic [8:0] word_al;
  logic [7:0] w_data;
  logic w_pbit;
  logic w_match;
  logic w_perr;
  logic [8:0] held_al;
  logic [7:0] w_data_held;
  logic held_pbit;
  logic held_perr;

  always_comb
  begin
    shf_next = {bitv, cur_ff.shf[8:1]};
    word_al = shf_next >> (4'h9 - n_word);
    w_data = word_al[7:0] & data_mask;
    w_pbit = word_al[n_data];
    w_match = (w_data == (cur_ff.sync_chr & data_mask));
    w_perr = par_en & ((^{w_data, w_pbit}) == par_even);
    // Word already held in the shift register, used while the stop bit is sampled
    held_al = cur_ff.shf >> (4'h9 - n_word);
    w_data_held = held_al[7:0] & data_mask;
    held_pbit = held_al[n_data];
    held_perr = par_en & ((^{w_data_held, held_pbit}) == par_even);
  end

  // Word completion events produced by the bit engine
  logic done;
  logic d_brk;
  logic d_fe;
  logic d_pe;
  logic d_match;
  logic found;
  logic err_word;
  logic strip;
  logic sts_rd;
  logic dat_rd;

  always_comb
  begin
    nxt_ff = cur_ff;
    nxt_ff.irq_full = 1'b0;
    nxt_ff.irq_err = 1'b0;
    nxt_ff.tx_en_d = tx_enabled;
    done = 1'b0;
    d_brk = 1'b0;
    d_fe = 1'b0;
    d_pe = 1'b0;
    d_match = 1'b0;
    found = 1'b0;
    err_word = 1'b0;
    strip = 1'b0;
    sts_rd = reg_rd && (reg_addr == SRSF_ADDR_STATUS);
    dat_rd = reg_rd && (reg_addr == SRSF_ADDR_DATA);

    // Register reads: data appear in the following cycle only
    nxt_ff.rdata = 8'h00;
    if (reg_rd)
    begin
      unique case (reg_addr)
        SRSF_ADDR_STATUS:
        begin
          nxt_ff.rdata = {cur_ff.bf, cur_ff.oe, cur_ff.pe, cur_ff.fe,
                          sync_fmt ? cur_ff.fs : cur_ff.brk,
                          sync_fmt ? cur_ff.m : cur_ff.char_in_progress_flag,
                          cur_ff.ss, cur_ff.re};
        end
        SRSF_ADDR_DATA:
        begin
          nxt_ff.rdata = cur_ff.data_buf;
        end
        SRSF_ADDR_SYNC:
        begin
          nxt_ff.rdata = cur_ff.sync_chr;
        end
        SRSF_ADDR_CTRL:
        begin
          nxt_ff.rdata = cur_ff.ctrl;
        end
        default:
        begin
          nxt_ff.rdata = 8'h00;
        end
      endcase
    end

    // Status read acknowledges overrun and any running break
    if (sts_rd)
    begin
      nxt_ff.oe = 1'b0;
      if (cur_ff.brk || cur_ff.brk_act)
      begin
        nxt_ff.brk_rd = 1'b1;
      end
    end

    // Data read frees the buffer; held-back conditions surface now
    if (dat_rd)
    begin
      nxt_ff.bf = 1'b0;
      if (cur_ff.ovr_pend)
      begin
        nxt_ff.oe = 1'b1;
        nxt_ff.ovr_pend = 1'b0;
        nxt_ff.irq_err = err_chan_en;
        nxt_ff.irq_full = ~err_chan_en;
      end
      if (cur_ff.brk_pend)
      begin
        nxt_ff.brk = 1'b1;
        nxt_ff.brk_pend = 1'b0;
        nxt_ff.irq_err = err_chan_en;
        nxt_ff.irq_full = ~err_chan_en;
      end
    end

    if (reg_wr)
    begin
      unique case (reg_addr)
        SRSF_ADDR_STATUS:
        begin
          nxt_ff.ss = reg_wdata[SRSF_STS_SS];
          nxt_ff.re = reg_wdata[SRSF_STS_RE];
          if (sync_fmt)
          begin
            nxt_ff.fs = reg_wdata[SRSF_STS_FSB];
            if (!reg_wdata[SRSF_STS_FSB])
            begin
              nxt_ff.st = SRSF_HUNT;
            end
          end
        end
        SRSF_ADDR_SYNC:
        begin
          nxt_ff.sync_chr = reg_wdata;
        end
        SRSF_ADDR_CTRL:
        begin
          nxt_ff.ctrl = reg_wdata;
          nxt_ff.st = reg_wdata[SRSF_CTL_SYNC] ? SRSF_HUNT : SRSF_IDLE;
          nxt_ff.cnt = 4'h0;
          nxt_ff.char_in_progress_flag = 1'b0;
        end
        default:
        begin
        end
      endcase
    end

    // Bit engine, one step per rising receiver clock edge
    if (tick && cur_ff.re)
    begin
      if (cur_ff.brk_act && bitv)
      begin
        nxt_ff.brk_act = 1'b0;
      end
      unique case (cur_ff.st)
        SRSF_IDLE:
        begin
          // No assembly while a break or an unread overrun is in force
          if (!bitv && !cur_ff.brk_act && !cur_ff.oe && !sync_fmt)
          begin
            nxt_ff.st = SRSF_DATA;
            nxt_ff.cnt = 4'h0;
            nxt_ff.shf = 9'h000;
            nxt_ff.char_in_progress_flag = 1'b1;
          end
        end
        SRSF_DATA:
        begin
          nxt_ff.shf = shf_next;
          nxt_ff.cnt = cur_ff.cnt + 4'h1;
          if (sync_fmt)
          begin
            if (cur_ff.cnt == n_word - 4'h1)
            begin
              done = 1'b1;
              nxt_ff.cnt = 4'h0;
              d_match = w_match;
              d_pe = w_perr;
              if (!w_match)
              begin
                nxt_ff.fs = 1'b0;
              end
            end
          end
          else if (cur_ff.cnt == n_word - 4'h1)
          begin
            nxt_ff.st = SRSF_STOP;
          end
        end
        SRSF_STOP:
        begin
          done = 1'b1;
          nxt_ff.st = SRSF_IDLE;
          nxt_ff.char_in_progress_flag = 1'b0;
          d_pe = 1'b0;
          if (!bitv && (w_data_held == 8'h00))
          begin
            d_brk = 1'b1;
          end
          else
          begin
            d_fe = ~bitv;
          end
        end
        SRSF_HUNT:
        begin
          // Word counter halts; every bit is a compare candidate
          nxt_ff.shf = shf_next;
          if (w_match)
          begin
            found = 1'b1;
            nxt_ff.fs = 1'b1;
            nxt_ff.st = SRSF_DATA;
            nxt_ff.cnt = 4'h0;
            nxt_ff.irq_err = err_chan_en;
            nxt_ff.irq_full = ~err_chan_en;
          end
        end
        default:
        begin
          nxt_ff.st = SRSF_IDLE;
        end
      endcase
    end

    if (done && !sync_fmt)
    begin
      d_pe = held_perr;
    end

    // Transfer to the receive buffer
    strip = sync_fmt && cur_ff.ss && d_match;
    err_word = d_pe || d_fe || d_brk;
    if (done && d_brk)
    begin
      nxt_ff.brk_act = 1'b1;
      nxt_ff.brk_rd = 1'b0;
    end
    if (done && !strip)
    begin
      // A data read in the same cycle frees the buffer for this word
      if (cur_ff.bf && !dat_rd)
      begin
        // Buffer and captured flags stay as they are
        if (d_brk)
        begin
          nxt_ff.brk_pend = 1'b1;
        end
        else
        begin
          nxt_ff.ovr_pend = 1'b1;
        end
      end
      else
      begin
        nxt_ff.data_buf = sync_fmt ? w_data : w_data_held;
        nxt_ff.bf = 1'b1;
        nxt_ff.pe = d_pe;
        nxt_ff.fe = d_fe;
        nxt_ff.brk = d_brk;
        nxt_ff.m = d_match;
        nxt_ff.irq_err = err_word && err_chan_en;
        nxt_ff.irq_full = !(err_word && err_chan_en);
      end
    end

    // End of break once the line went high and status was seen
    if (cur_ff.brk && !cur_ff.brk_act && cur_ff.brk_rd && !(done && d_brk) && !dat_rd)
    begin
      nxt_ff.brk = 1'b0;
      nxt_ff.brk_rd = 1'b0;
      nxt_ff.irq_err = err_chan_en;
      nxt_ff.irq_full = ~err_chan_en;
    end

    // Transmitter going idle hands the line back to the receiver
    if (cur_ff.ctrl[SRSF_CTL_AUTO] && cur_ff.tx_en_d && !tx_enabled)
    begin
      nxt_ff.re = 1'b1;
    end

    // Disabled receiver: all flags down, engine parked
    if (!nxt_ff.re)
    begin
      nxt_ff.bf = 1'b0;
      nxt_ff.oe = 1'b0;
      nxt_ff.pe = 1'b0;
      nxt_ff.fe = 1'b0;
      nxt_ff.fs = 1'b0;
      nxt_ff.brk = 1'b0;
      nxt_ff.m = 1'b0;
      nxt_ff.char_in_progress_flag = 1'b0;
      nxt_ff.ovr_pend = 1'b0;
      nxt_ff.brk_pend = 1'b0;
      nxt_ff.brk_act = 1'b0;
      nxt_ff.brk_rd = 1'b0;
      nxt_ff.irq_full = 1'b0;
      nxt_ff.irq_err = 1'b0;
      nxt_ff.st = sync_fmt ? SRSF_HUNT : SRSF_IDLE;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      cur_ff <= '{default: '0, st: SRSF_IDLE, ctrl: SRSF_CTRL_RST,
                 sync_chr: SRSF_SYNC_RST, data_buf: SRSF_DATA_RST};
    end
    else
    begin
      cur_ff <= nxt_ff;
    end
  end

  assign reg_rdata = cur_ff.rdata;
  assign irq_buffer_full = cur_ff.irq_full;
  assign irq_rx_error = cur_ff.irq_err;
  assign rx_enabled = cur_ff.re;

endmodule

//--- tb/srsf_receiver_monitor.sv
`timescale 1ns/100ps
module srsf_receiver_monitor
  import srsf_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic rx_clk_pin,
  input wire logic rx_data_pin,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic tx_enabled,
  input wire logic err_chan_en,
  input wire logic irq_buffer_full,
  input wire logic irq_rx_error,
  input wire logic rx_enabled
);
  logic auto_ff;
  logic wbit_ff;
  logic any_irq;
  logic st_rd;
  assign any_irq = irq_buffer_full | irq_rx_error;
  assign st_rd = reg_rd && reg_addr == SRSF_ADDR_STATUS;
  // Shadow of the turnaround control and of the enable bit on the write data of the previous cycle
  always_ff @(posedge clock)
  begin
    wbit_ff <= reg_wdata[SRSF_STS_RE];
    if (rst)
      auto_ff <= 1'b0;
    else if (reg_wr && reg_addr == SRSF_ADDR_CTRL)
      auto_ff <= reg_wdata[SRSF_CTL_AUTO];
  end
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  chk_reset_clears: assert property ($past(rst) |-> !rx_enabled && !any_irq && reg_rdata == 8'h00)
    else $error("outputs not clear after reset");
  chk_status_re_bit: assert property ($past(st_rd) |-> reg_rdata[0] == $past(rx_enabled))
    else $error("status enable bit differs from output");
  chk_off_flags_clear: assert property ($past(st_rd) && !$past(rx_enabled) |-> reg_rdata[7:2] == 6'h00)
    else $error("flags set while receiver off");
  chk_re_write: assert property (reg_wr && reg_addr == SRSF_ADDR_STATUS && !auto_ff |=> rx_enabled == wbit_ff)
    else $error("enable write not taken");
  chk_auto_turn: assert property (auto_ff && $fell(tx_enabled) |-> ##[1:2] rx_enabled)
    else $error("turnaround did not enable receiver");
  chk_off_quiet: assert property (!rx_enabled && !$past(rx_enabled) |-> !any_irq)
    else $error("interrupt while receiver off");
  chk_err_chan_off: assert property (!err_chan_en && !$past(err_chan_en) |-> !irq_rx_error)
    else $error("error channel used while disabled");
  chk_irq_one_cycle: assert property (any_irq |=> !any_irq)
    else $error("interrupt longer than one cycle");
  chk_irq_one_chan: assert property (!(irq_buffer_full && irq_rx_error))
    else $error("both interrupt channels at once");
  cov_full: cover property (irq_buffer_full);
  cov_err: cover property (irq_rx_error);
  cov_turn: cover property (auto_ff && $fell(tx_enabled));
endmodule
bind srsf_receiver srsf_receiver_monitor u_mon (.clock(clock), .rst(rst),
  .rx_clk_pin(rx_clk_pin), .rx_data_pin(rx_data_pin), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .tx_enabled(tx_enabled), .err_chan_en(err_chan_en), .irq_buffer_full(irq_buffer_full),
  .irq_rx_error(irq_rx_error), .rx_enabled(rx_enabled));

//--- tb/srsf_remote_tx.sv
`timescale 1ns/100ps
module srsf_remote_tx
(
  output logic rx_clk_pin,
  output logic rx_data_pin
);
  initial
  begin
    rx_clk_pin = 1'b0;
    rx_data_pin = 1'b1;
  end
  // Bits go out LSB first; the link clock runs only inside a frame
  task automatic send(input logic [10:0] bits, input int n, input logic idle);
    int i;
    for (i = 0; i < n; i++)
    begin
      rx_data_pin = bits[i];
      #40;
      rx_clk_pin = 1'b1;
      #80;
      rx_clk_pin = 1'b0;
      #40;
    end
    // Mark level when released; a break holds the line low
    rx_data_pin = idle;
  endtask
endmodule

//--- tb/test_serial_receiver_status_flags.sv
`timescale 1ns/100ps
module test_serial_receiver_status_flags
  import srsf_pkg::*;
;
  typedef struct packed {
    logic [7:0] ctrl;
    logic errch;
    logic [10:0] frm;
    logic [3:0] n;
    logic idle;
    logic [7:0] irq;
    logic [7:0] st;
    logic [7:0] dat;
  } srsf_row_t;
  localparam srsf_row_t ROWS [8] = '{
    '{8'h00, 1'b0, 11'h2AA, 4'hA, 1'b1, 8'h01, 8'h81, 8'h55},
    '{8'h06, 1'b0, 11'h06A, 4'h7, 1'b1, 8'h01, 8'h81, 8'h15},
    '{8'h08, 1'b0, 11'h6AA, 4'hB, 1'b1, 8'h01, 8'h81, 8'h55},
    '{8'h18, 1'b1, 11'h6AA, 4'hB, 1'b1, 8'h02, 8'hA1, 8'h55},
    '{8'h18, 1'b0, 11'h6AA, 4'hB, 1'b1, 8'h01, 8'hA1, 8'h55},
    '{8'h18, 1'b0, 11'h4AA, 4'hB, 1'b1, 8'h01, 8'h81, 8'h55},
    '{8'h00, 1'b1, 11'h078, 4'hA, 1'b1, 8'h02, 8'h91, 8'h3C},
    '{8'h00, 1'b1, 11'h000, 4'hA, 1'b0, 8'h02, 8'h89, 8'h00}};
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic tx_enabled = 1'b0;
  logic err_chan_en = 1'b0;
  logic [7:0] reg_rdata;
  logic irq_buffer_full;
  logic irq_rx_error;
  logic rx_enabled;
  wire rx_clk_pin;
  wire rx_data_pin;
  int mismatches = 0;
  int n_tests = 0;
  always #2.5 clock = ~clock;
  srsf_remote_tx u_tx (.rx_clk_pin(rx_clk_pin), .rx_data_pin(rx_data_pin));
  srsf_receiver u_dut (.clock(clock), .rst(rst), .rx_clk_pin(rx_clk_pin),
    .rx_data_pin(rx_data_pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_enabled(tx_enabled),
    .err_chan_en(err_chan_en), .irq_buffer_full(irq_buffer_full),
    .irq_rx_error(irq_rx_error), .rx_enabled(rx_enabled));
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m = 8'hFF);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata & m, exp);
  endtask
  // Waits for one interrupt pulse; bit 0 is buffer full, bit 1 error
  task automatic wirq(input logic [7:0] exp);
    int i;
    logic [7:0] seen;
    seen = 8'h00;
    for (i = 0; i < 600 && seen == 8'h00; i++)
    begin
      @(negedge clock);
      seen = {6'h00, irq_rx_error, irq_buffer_full};
    end
    chk(seen, exp);
    if (seen == 8'h00 && exp != 8'h00)
      summarize();
  endtask
  task automatic xfer(input logic [10:0] f, input int n, input logic idle, input logic [7:0] q);
    fork
      u_tx.send(f, n, idle);
      wirq(q);
    join
  endtask
  initial
  begin
    srsf_row_t r;
    int k;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rd(SRSF_ADDR_STATUS, SRSF_STATUS_RST);
    rd(SRSF_ADDR_CTRL, SRSF_CTRL_RST);
    wr(8'h10, 8'hFF);
    rd(8'h10, 8'h00);
    // Frames only start after the enable write has landed
    wr(SRSF_ADDR_STATUS, 8'h01);
    rd(SRSF_ADDR_STATUS, 8'h01);
    for (k = 0; k < 8; k++)
    begin
      r = ROWS[k];
      wr(SRSF_ADDR_CTRL, r.ctrl);
      err_chan_en <= r.errch;
      fork
        u_tx.send(r.frm, r.n, r.idle);
        begin
          repeat (100) @(posedge clock);
          rd(SRSF_ADDR_STATUS, 8'h05, 8'h85);
          wirq(r.irq);
        end
      join
      rd(SRSF_ADDR_STATUS, r.st);
      rd(SRSF_ADDR_DATA, r.dat);
    end
    xfer(11'h001, 1, 1'b1, 8'h02);
    rd(SRSF_ADDR_STATUS, 8'h01);
    wr(SRSF_ADDR_CTRL, 8'h00);
    xfer(11'h2AA, 10, 1'b1, 8'h01);
    xfer(11'h244, 10, 1'b1, 8'h00);
    rd(SRSF_ADDR_STATUS, 8'h81);
    rd(SRSF_ADDR_DATA, 8'h55);
    wirq(8'h02);
    rd(SRSF_ADDR_STATUS, 8'h41);
    rd(SRSF_ADDR_STATUS, 8'h01);
    wr(SRSF_ADDR_CTRL, 8'h01);
    wr(SRSF_ADDR_SYNC, 8'h96);
    xfer(11'h096, 8, 1'b1, 8'h02);
    rd(SRSF_ADDR_STATUS, 8'h09);
    xfer(11'h096, 8, 1'b1, 8'h01);
    rd(SRSF_ADDR_STATUS, 8'h8D);
    rd(SRSF_ADDR_DATA, 8'h96);
    wr(SRSF_ADDR_STATUS, 8'h0B);
    xfer(11'h096, 8, 1'b1, 8'h00);
    rd(SRSF_ADDR_STATUS, 8'h0B, 8'h8B);
    xfer(11'h03C, 8, 1'b1, 8'h01);
    rd(SRSF_ADDR_STATUS, 8'h83);
    wr(SRSF_ADDR_STATUS, 8'h00);
    rd(SRSF_ADDR_STATUS, 8'h00);
    xfer(11'h096, 8, 1'b1, 8'h00);
    wr(SRSF_ADDR_CTRL, 8'h20);
    @(posedge clock);
    tx_enabled <= 1'b1;
    @(posedge clock);
    tx_enabled <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
    chk({7'h00, rx_enabled}, 8'h01);
    rd(SRSF_ADDR_STATUS, 8'h01);
    wr(SRSF_ADDR_STATUS, 8'h03);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rd(SRSF_ADDR_STATUS, 8'h00);
    summarize();
  end
endmodule
